// ---- hw/module_disable_pkg.sv ----
package module_disable_pkg;

  localparam int ADDR_W = 3;
  localparam int REG_W = 8;
  localparam int BUS_W = 32;
  localparam int NUM_REGS = 5;

  localparam logic [ADDR_W-1:0] CTRL0_ADDR = 3'h0;
  localparam logic [ADDR_W-1:0] CTRL1_ADDR = 3'h1;
  localparam logic [ADDR_W-1:0] CTRL2_ADDR = 3'h2;
  localparam logic [ADDR_W-1:0] CTRL3_ADDR = 3'h3;
  localparam logic [ADDR_W-1:0] CTRL4_ADDR = 3'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 3'h5;

  localparam logic [REG_W-1:0] CTRL0_MASK = 8'hC7;
  localparam logic [REG_W-1:0] CTRL1_MASK = 8'h87;
  localparam logic [REG_W-1:0] CTRL2_MASK = 8'h67;
  localparam logic [REG_W-1:0] CTRL3_MASK = 8'h3F;
  localparam logic [REG_W-1:0] CTRL4_MASK = 8'hD1;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

  localparam int B0_SYSTEM_CLOCK_NET = 7;
  localparam int B0_VREF = 6;
  localparam int B0_MEMCTL = 2;
  localparam int B0_REFCLK = 1;
  localparam int B0_PINCHG = 0;
  localparam int B1_NUMOSC = 7;
  localparam int B1_TMR2 = 2;
  localparam int B1_TMR1 = 1;
  localparam int B1_TMR0 = 0;
  localparam int B2_DAC = 6;
  localparam int B2_ADC = 5;
  localparam int B2_CMP2 = 2;
  localparam int B2_CMP1 = 1;
  localparam int B2_ZCD = 0;
  localparam int B3_PWM6 = 5;
  localparam int B3_PWM5 = 4;
  localparam int B3_PWM4 = 3;
  localparam int B3_PWM3 = 2;
  localparam int B3_CCP2 = 1;
  localparam int B3_CCP1 = 0;
  localparam int B4_SER2 = 7;
  localparam int B4_SER1 = 6;
  localparam int B4_SYNC = 4;
  localparam int B4_CWG = 0;

  localparam int MEM_WAKE_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MEM_WAKE_CYCLES = MEM_WAKE_NS / CLK_PERIOD_NS;
  localparam int WAKE_W = 7;
  localparam int RECOVER_CYCLES = 1;

  typedef struct packed {
    logic system_clock_net_net_off;
    logic volt_ref_off;
    logic memctl_off;
    logic refclk_out_off;
    logic pin_change_irq_off;
    logic num_osc_off;
    logic timer_two_off;
    logic timer_one_off;
    logic timer_zero_off;
    logic da_conv_off;
    logic ad_conv_off;
    logic comparator_two_off;
    logic comparator_one_off;
    logic zero_cross_off;
    logic modulator_six_off;
    logic modulator_five_off;
    logic modulator_four_off;
    logic modulator_three_off;
    logic capcomp_two_off;
    logic capcomp_one_off;
    logic serial_port_two_off;
    logic serial_port_one_off;
    logic sync_serial_off;
    logic waveform_gen_off;
  } disables_t;

endpackage

// ---- hw/module_disable_bank.sv ----
// Notes on behaviour
// [R1] Master bit stops system clock distribution.
// [R2] Master bit gates only system-clocked peripherals.
// [R3] Control 0 bit 6 disables voltage reference.
// [R4] Memory disable blocks access, reads zero.
// [R5] Software waits 1 us before memory.
// [R6] Control 0 bit 1 disables reference clock.
// [R7] Control 0 bit 0 disables pin-change logic.
// [R8] Control 1 bit 7 disables numeric oscillator.
// [R9] Control 1 bits 2..0 disable timers.
// [R10] Control 2 bits 6,5 disable converters.
// [R11] Control 2 bits 2..0 comparators, zero-cross.
// [R12] Control 3 bits 5..2 disable modulators.
// [R13] Control 3 bits 1,0 disable capture units.
// [R14] Control 4 bits 7,6 disable serial ports.
// [R15] Control 4 bits 4,0 sync serial, waveform.
// [R16] Unimplemented bits ignore writes, read zero.
// [R17] All disable bits reset to zero.
// [R18] Disabled module held reset, clock stopped.
// [R19] Re-enabled module waits one cycle recovery.
// [R20] Disable also disables its pin-select routing.
// [R21] Disable outputs registered, glitch-free.
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module peripheral_module_disable_bank
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [module_disable_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [module_disable_pkg::BUS_W-1:0] avs_writedata_in,
  output logic [module_disable_pkg::BUS_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic system_clock_net_gate_en_out,
  output module_disable_pkg::disables_t clk_off_out,
  output module_disable_pkg::disables_t reset_hold_out,
  output module_disable_pkg::disables_t pin_select_off_out,
  output logic mem_ready_out
);

  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] ctrl3_q;
  logic [7:0] ctrl4_q;
  logic ack_q;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  module_disable_pkg::disables_t dis_d;
  module_disable_pkg::disables_t dis_q;
  module_disable_pkg::disables_t hold_q;
  logic [module_disable_pkg::WAKE_W-1:0] wake_q;
  localparam int WAKE_LAST = module_disable_pkg::MEM_WAKE_CYCLES - 1;

  // One wait state per access keeps the answer registered.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign wr_acc = avs_write_in & ack_q & avs_byteenable_in[0];
  assign rd_acc = avs_read_in & ~ack_q;
  assign wbyte = avs_writedata_in[7:0];

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      ack_q <= 1'b0;
    else if (clk_en_in)
      ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl0_q <= module_disable_pkg::CTRL_RESET; // R17
      ctrl1_q <= module_disable_pkg::CTRL_RESET;
      ctrl2_q <= module_disable_pkg::CTRL_RESET;
      ctrl3_q <= module_disable_pkg::CTRL_RESET;
      ctrl4_q <= module_disable_pkg::CTRL_RESET;
    end
    else if (clk_en_in && wr_acc)
    begin
      unique case (avs_address_in)
        module_disable_pkg::CTRL0_ADDR: ctrl0_q <= wbyte & module_disable_pkg::CTRL0_MASK; // R16
        module_disable_pkg::CTRL1_ADDR: ctrl1_q <= wbyte & module_disable_pkg::CTRL1_MASK; // R16
        module_disable_pkg::CTRL2_ADDR: ctrl2_q <= wbyte & module_disable_pkg::CTRL2_MASK; // R16
        module_disable_pkg::CTRL3_ADDR: ctrl3_q <= wbyte & module_disable_pkg::CTRL3_MASK; // R16
        module_disable_pkg::CTRL4_ADDR: ctrl4_q <= wbyte & module_disable_pkg::CTRL4_MASK; // R16
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      avs_readdata_out <= '0;
    else if (clk_en_in && rd_acc)
    begin
      unique case (avs_address_in)
        module_disable_pkg::CTRL0_ADDR: avs_readdata_out <= {24'h000000, ctrl0_q};
        module_disable_pkg::CTRL1_ADDR: avs_readdata_out <= {24'h000000, ctrl1_q};
        module_disable_pkg::CTRL2_ADDR: avs_readdata_out <= {24'h000000, ctrl2_q};
        module_disable_pkg::CTRL3_ADDR: avs_readdata_out <= {24'h000000, ctrl3_q};
        module_disable_pkg::CTRL4_ADDR: avs_readdata_out <= {24'h000000, ctrl4_q};
        module_disable_pkg::STATUS_ADDR: avs_readdata_out <= {31'h00000000, mem_ready_out};
        default: avs_readdata_out <= '0;
      endcase
    end
  end

  always_comb
  begin
    dis_d.system_clock_net_net_off = ctrl0_q[module_disable_pkg::B0_SYSTEM_CLOCK_NET]; // R1
    dis_d.volt_ref_off = ctrl0_q[module_disable_pkg::B0_VREF]; // R3
    dis_d.memctl_off = ctrl0_q[module_disable_pkg::B0_MEMCTL]; // R4
    dis_d.refclk_out_off = ctrl0_q[module_disable_pkg::B0_REFCLK]; // R6
    dis_d.pin_change_irq_off = ctrl0_q[module_disable_pkg::B0_PINCHG]; // R7
    dis_d.num_osc_off = ctrl1_q[module_disable_pkg::B1_NUMOSC]; // R8
    dis_d.timer_two_off = ctrl1_q[module_disable_pkg::B1_TMR2]; // R9
    dis_d.timer_one_off = ctrl1_q[module_disable_pkg::B1_TMR1]; // R9
    dis_d.timer_zero_off = ctrl1_q[module_disable_pkg::B1_TMR0]; // R9
    dis_d.da_conv_off = ctrl2_q[module_disable_pkg::B2_DAC]; // R10
    dis_d.ad_conv_off = ctrl2_q[module_disable_pkg::B2_ADC]; // R10
    dis_d.comparator_two_off = ctrl2_q[module_disable_pkg::B2_CMP2]; // R11
    dis_d.comparator_one_off = ctrl2_q[module_disable_pkg::B2_CMP1]; // R11
    dis_d.zero_cross_off = ctrl2_q[module_disable_pkg::B2_ZCD]; // R11
    dis_d.modulator_six_off = ctrl3_q[module_disable_pkg::B3_PWM6]; // R12
    dis_d.modulator_five_off = ctrl3_q[module_disable_pkg::B3_PWM5]; // R12
    dis_d.modulator_four_off = ctrl3_q[module_disable_pkg::B3_PWM4]; // R12
    dis_d.modulator_three_off = ctrl3_q[module_disable_pkg::B3_PWM3]; // R12
    dis_d.capcomp_two_off = ctrl3_q[module_disable_pkg::B3_CCP2]; // R13
    dis_d.capcomp_one_off = ctrl3_q[module_disable_pkg::B3_CCP1]; // R13
    dis_d.serial_port_two_off = ctrl4_q[module_disable_pkg::B4_SER2]; // R14
    dis_d.serial_port_one_off = ctrl4_q[module_disable_pkg::B4_SER1]; // R14
    dis_d.sync_serial_off = ctrl4_q[module_disable_pkg::B4_SYNC]; // R15
    dis_d.waveform_gen_off = ctrl4_q[module_disable_pkg::B4_CWG]; // R15
  end

  // Registering the disables keeps gate enables free of decode glitches.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      dis_q <= '0;
    else if (clk_en_in)
      dis_q <= dis_d; // R21
  end

  // Reset is held one cycle past the clock release so the module wakes clean.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      hold_q <= '0;
    else if (clk_en_in)
      hold_q <= dis_q; // R19
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      wake_q <= '0;
    else if (clk_en_in)
    begin
      if (dis_q.memctl_off)
        wake_q <= module_disable_pkg::MEM_WAKE_CYCLES[module_disable_pkg::WAKE_W-1:0]; // R5
      else if (wake_q != '0)
        wake_q <= wake_q - 1'b1;
    end
  end

  // Only the system network gate follows the master bit; other clocks run on.
  assign system_clock_net_gate_en_out = ~dis_q.system_clock_net_net_off; // R1 R2
  assign clk_off_out = dis_q; // R18
  assign reset_hold_out = dis_q | hold_q; // R18 R19
  assign pin_select_off_out = dis_q; // R20
  // Memory access is blocked while disabled and through the wake delay.
  assign mem_ready_out = ~dis_q.memctl_off & (wake_q == '0); // R4

  a_disable_follows: assert property (@(posedge clock_in) disable iff (rst_in) // R21
    clk_en_in |=> (dis_q == $past(dis_d)))
    else $error("disable outputs did not follow control bits");

  a_system_clock_net_gate: assert property (@(posedge clock_in) disable iff (rst_in) // R1
    system_clock_net_gate_en_out != dis_q.system_clock_net_net_off)
    else $error("system clock gate disagrees with master bit");

  a_system_clock_net_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R1
    clk_en_in |=> clk_off_out.system_clock_net_net_off == $past(ctrl0_q[module_disable_pkg::B0_SYSTEM_CLOCK_NET]))
    else $error("master disable lost its bit");

  a_vref_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R3
    clk_en_in |=> clk_off_out.volt_ref_off == $past(ctrl0_q[module_disable_pkg::B0_VREF]))
    else $error("reference disable lost its bit");

  a_memctl_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R4
    clk_en_in |=> clk_off_out.memctl_off == $past(ctrl0_q[module_disable_pkg::B0_MEMCTL]))
    else $error("memory disable lost its bit");

  a_refclk_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R6
    clk_en_in |=> clk_off_out.refclk_out_off == $past(ctrl0_q[module_disable_pkg::B0_REFCLK]))
    else $error("clock output disable lost its bit");

  a_pinchg_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R7
    clk_en_in |=> clk_off_out.pin_change_irq_off == $past(ctrl0_q[module_disable_pkg::B0_PINCHG]))
    else $error("pin change disable lost its bit");

  a_numosc_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R8
    clk_en_in |=> clk_off_out.num_osc_off == $past(ctrl1_q[module_disable_pkg::B1_NUMOSC]))
    else $error("oscillator disable lost its bit");

  a_timer_two_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R9
    clk_en_in |=> clk_off_out.timer_two_off == $past(ctrl1_q[module_disable_pkg::B1_TMR2]))
    else $error("timer two disable lost its bit");

  a_timer_one_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R9
    clk_en_in |=> clk_off_out.timer_one_off == $past(ctrl1_q[module_disable_pkg::B1_TMR1]))
    else $error("timer one disable lost its bit");

  a_timer_zero_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R9
    clk_en_in |=> clk_off_out.timer_zero_off == $past(ctrl1_q[module_disable_pkg::B1_TMR0]))
    else $error("timer zero disable lost its bit");

  a_da_conv_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R10
    clk_en_in |=> clk_off_out.da_conv_off == $past(ctrl2_q[module_disable_pkg::B2_DAC]))
    else $error("output converter disable lost its bit");

  a_ad_conv_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R10
    clk_en_in |=> clk_off_out.ad_conv_off == $past(ctrl2_q[module_disable_pkg::B2_ADC]))
    else $error("input converter disable lost its bit");

  a_cmp_two_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R11
    clk_en_in |=> clk_off_out.comparator_two_off == $past(ctrl2_q[module_disable_pkg::B2_CMP2]))
    else $error("comparator two disable lost its bit");

  a_cmp_one_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R11
    clk_en_in |=> clk_off_out.comparator_one_off == $past(ctrl2_q[module_disable_pkg::B2_CMP1]))
    else $error("comparator one disable lost its bit");

  a_zero_cross_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R11
    clk_en_in |=> clk_off_out.zero_cross_off == $past(ctrl2_q[module_disable_pkg::B2_ZCD]))
    else $error("zero cross disable lost its bit");

  a_mod_six_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R12
    clk_en_in |=> clk_off_out.modulator_six_off == $past(ctrl3_q[module_disable_pkg::B3_PWM6]))
    else $error("modulator six disable lost its bit");

  a_mod_five_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R12
    clk_en_in |=> clk_off_out.modulator_five_off == $past(ctrl3_q[module_disable_pkg::B3_PWM5]))
    else $error("modulator five disable lost its bit");

  a_mod_four_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R12
    clk_en_in |=> clk_off_out.modulator_four_off == $past(ctrl3_q[module_disable_pkg::B3_PWM4]))
    else $error("modulator four disable lost its bit");

  a_mod_three_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R12
    clk_en_in |=> clk_off_out.modulator_three_off == $past(ctrl3_q[module_disable_pkg::B3_PWM3]))
    else $error("modulator three disable lost its bit");

  a_capcomp_two_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R13
    clk_en_in |=> clk_off_out.capcomp_two_off == $past(ctrl3_q[module_disable_pkg::B3_CCP2]))
    else $error("capture two disable lost its bit");

  a_capcomp_one_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R13
    clk_en_in |=> clk_off_out.capcomp_one_off == $past(ctrl3_q[module_disable_pkg::B3_CCP1]))
    else $error("capture one disable lost its bit");

  a_serial_two_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R14
    clk_en_in |=> clk_off_out.serial_port_two_off == $past(ctrl4_q[module_disable_pkg::B4_SER2]))
    else $error("serial two disable lost its bit");

  a_serial_one_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R14
    clk_en_in |=> clk_off_out.serial_port_one_off == $past(ctrl4_q[module_disable_pkg::B4_SER1]))
    else $error("serial one disable lost its bit");

  a_sync_serial_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R15
    clk_en_in |=> clk_off_out.sync_serial_off == $past(ctrl4_q[module_disable_pkg::B4_SYNC]))
    else $error("sync serial disable lost its bit");

  a_waveform_bit: assert property (@(posedge clock_in) disable iff (rst_in) // R15
    clk_en_in |=> clk_off_out.waveform_gen_off == $past(ctrl4_q[module_disable_pkg::B4_CWG]))
    else $error("waveform disable lost its bit");

  a_unimpl_zero: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (ctrl0_q & ~module_disable_pkg::CTRL0_MASK) == '0)
    else $error("unimplemented bits of control 0 set");

  a_unimpl_one: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (ctrl1_q & ~module_disable_pkg::CTRL1_MASK) == '0)
    else $error("unimplemented bits of control 1 set");

  a_unimpl_two: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (ctrl2_q & ~module_disable_pkg::CTRL2_MASK) == '0)
    else $error("unimplemented bits of control 2 set");

  a_unimpl_three: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (ctrl3_q & ~module_disable_pkg::CTRL3_MASK) == '0)
    else $error("unimplemented bits of control 3 set");

  a_unimpl_four: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (ctrl4_q & ~module_disable_pkg::CTRL4_MASK) == '0)
    else $error("unimplemented bits of control 4 set");

  a_write_zero: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && wr_acc && avs_address_in == module_disable_pkg::CTRL0_ADDR)
    |=> ctrl0_q == $past(wbyte & module_disable_pkg::CTRL0_MASK))
    else $error("write to control 0 did not land");

  a_write_one: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && wr_acc && avs_address_in == module_disable_pkg::CTRL1_ADDR)
    |=> ctrl1_q == $past(wbyte & module_disable_pkg::CTRL1_MASK))
    else $error("write to control 1 did not land");

  a_write_two: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && wr_acc && avs_address_in == module_disable_pkg::CTRL2_ADDR)
    |=> ctrl2_q == $past(wbyte & module_disable_pkg::CTRL2_MASK))
    else $error("write to control 2 did not land");

  a_write_three: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && wr_acc && avs_address_in == module_disable_pkg::CTRL3_ADDR)
    |=> ctrl3_q == $past(wbyte & module_disable_pkg::CTRL3_MASK))
    else $error("write to control 3 did not land");

  a_write_four: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && wr_acc && avs_address_in == module_disable_pkg::CTRL4_ADDR)
    |=> ctrl4_q == $past(wbyte & module_disable_pkg::CTRL4_MASK))
    else $error("write to control 4 did not land");

  a_read_zero: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && rd_acc && avs_address_in == module_disable_pkg::CTRL0_ADDR)
    |=> avs_readdata_out[module_disable_pkg::REG_W-1:0] == $past(ctrl0_q))
    else $error("read of control 0 wrong");

  a_read_one: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && rd_acc && avs_address_in == module_disable_pkg::CTRL1_ADDR)
    |=> avs_readdata_out[module_disable_pkg::REG_W-1:0] == $past(ctrl1_q))
    else $error("read of control 1 wrong");

  a_read_two: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && rd_acc && avs_address_in == module_disable_pkg::CTRL2_ADDR)
    |=> avs_readdata_out[module_disable_pkg::REG_W-1:0] == $past(ctrl2_q))
    else $error("read of control 2 wrong");

  a_read_three: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && rd_acc && avs_address_in == module_disable_pkg::CTRL3_ADDR)
    |=> avs_readdata_out[module_disable_pkg::REG_W-1:0] == $past(ctrl3_q))
    else $error("read of control 3 wrong");

  a_read_four: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    (clk_en_in && rd_acc && avs_address_in == module_disable_pkg::CTRL4_ADDR)
    |=> avs_readdata_out[module_disable_pkg::REG_W-1:0] == $past(ctrl4_q))
    else $error("read of control 4 wrong");

  a_read_upper: assert property (@(posedge clock_in) disable iff (rst_in) // R16
    avs_readdata_out[module_disable_pkg::BUS_W-1:module_disable_pkg::REG_W] == '0)
    else $error("upper read data not zero");

  a_mem_blocked: assert property (@(posedge clock_in) disable iff (rst_in) // R4
    dis_q.memctl_off |-> !mem_ready_out)
    else $error("memory ready while memory disabled");

  a_mem_wake: assert property (@(posedge clock_in) disable iff (rst_in) // R5
    (clk_en_in && $fell(dis_q.memctl_off)) |-> !mem_ready_out[*8])
    else $error("memory ready before wake delay");

  a_mem_wake_end: assert property (@(posedge clock_in) disable iff (rst_in) // R5
    (clk_en_in && $fell(dis_q.memctl_off)) |-> ##WAKE_LAST !mem_ready_out)
    else $error("memory wake delay too short");

  a_hold_covers: assert property (@(posedge clock_in) disable iff (rst_in) // R18
    (clk_off_out & ~reset_hold_out) == '0)
    else $error("disabled module not held in reset");

  a_reset_linger: assert property (@(posedge clock_in) disable iff (rst_in) // R19
    (clk_en_in && $fell(dis_q.timer_zero_off)) |-> reset_hold_out.timer_zero_off)
    else $error("reset released with clock");

  a_wait_ack: assert property (@(posedge clock_in) disable iff (rst_in)
    (avs_read_in && clk_en_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("wait state longer than one cycle");

  a_pin_select: assert property (@(posedge clock_in) disable iff (rst_in) // R20
    pin_select_off_out == clk_off_out)
    else $error("pin select disable disagrees");

endmodule

`default_nettype wire

// ---- dv/peripheral_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module peripheral_far_model
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic system_clock_net_gate_en_in,
  input wire logic run_off_in,
  input wire logic hold_in,
  output logic [7:0] ticks_out
);
  // A held peripheral loses its count, so a re-enabled one starts from zero.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in || hold_in)
      ticks_out <= 8'h00;
    else if (system_clock_net_gate_en_in && !run_off_in)
      ticks_out <= ticks_out + 8'h01;
  end
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] r; logic [23:0] d;} row_t;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [module_disable_pkg::ADDR_W-1:0] addr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic gate_en;
  logic mem_ready;
  module_disable_pkg::disables_t clk_off;
  module_disable_pkg::disables_t hold;
  module_disable_pkg::disables_t pin_off;
  logic [7:0] ticks;
  logic [7:0] frozen;
  logic [31:0] got;
  logic last_off = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  int i;
  row_t rows [15];

  peripheral_module_disable_bank peripheral_module_disable_bank_inst
  (
    .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .system_clock_net_gate_en_out(gate_en),
    .clk_off_out(clk_off), .reset_hold_out(hold), .pin_select_off_out(pin_off),
    .mem_ready_out(mem_ready)
  );

  peripheral_far_model peripheral_far_model_inst
  (
    .clock_in(clock_in), .rst_in(rst_in), .system_clock_net_gate_en_in(gate_en),
    .run_off_in(clk_off.timer_zero_off), .hold_in(hold.timer_zero_off), .ticks_out(ticks)
  );

  always #5 clock_in = ~clock_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask

  // The slave answers in its own time; only the watchdog or this bound ends a wait.
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    @(posedge clock_in);
    while (waitreq !== 1'b0 && n < 50)
    begin
      @(posedge clock_in);
      n++;
    end
    if (n == 50)
    begin
      err_count++;
      complete_run();
    end
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // A peripheral leaving its disabled state must still be held for that cycle.
  always @(posedge clock_in)
  begin
    #1;
    if (last_off && !clk_off.timer_zero_off && !rst_in)
      check(hold.timer_zero_off, 1'b1);
    last_off = clk_off.timer_zero_off;
  end

  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end

  initial
  begin
    rows = '{'{3'h0, 8'hAA, 8'h82, 24'h900000}, '{3'h0, 8'h55, 8'h45, 24'h680000},
             '{3'h0, 8'h00, 8'h00, 24'h000000}, '{3'h1, 8'hAA, 8'h82, 24'h050000},
             '{3'h1, 8'h55, 8'h05, 24'h028000}, '{3'h1, 8'h00, 8'h00, 24'h000000},
             '{3'h2, 8'hAA, 8'h22, 24'h002800}, '{3'h2, 8'h55, 8'h45, 24'h005400},
             '{3'h2, 8'h00, 8'h00, 24'h000000}, '{3'h3, 8'hAA, 8'h2A, 24'h0002A0},
             '{3'h3, 8'h55, 8'h15, 24'h000150}, '{3'h3, 8'h00, 8'h00, 24'h000000},
             '{3'h4, 8'hAA, 8'h80, 24'h000008}, '{3'h4, 8'h55, 8'h51, 24'h000007},
             '{3'h4, 8'h00, 8'h00, 24'h000000}};
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    tick(1);
    check({8'h00, clk_off}, 32'h0);
    check(gate_en, 1'b1);
    for (i = 0; i < 15; i++)
    begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 8'h00);
      check(got, {24'h000000, rows[i].r});
      tick(2);
      check({8'h00, clk_off}, {8'h00, rows[i].d});
      check({8'h00, pin_off}, {8'h00, rows[i].d});
      check({8'h00, hold}, {8'h00, rows[i].d});
      check(gate_en, !rows[i].d[23]);
    end
    bus(1'b1, 3'h0, 8'h04);
    bus(1'b0, 3'h5, 8'h00);
    check(got, 32'h0);
    bus(1'b1, 3'h0, 8'h00);
    tick(90);
    check(mem_ready, 1'b0);
    tick(20);
    bus(1'b0, 3'h5, 8'h00);
    check(got, 32'h1);
    bus(1'b1, 3'h6, 8'hFF);
    bus(1'b0, 3'h6, 8'h00);
    check(got, 32'h0);
    be <= 4'h0;
    bus(1'b1, 3'h1, 8'hFF);
    be <= 4'hF;
    bus(1'b0, 3'h1, 8'h00);
    check(got, 32'h0);
    bus(1'b1, 3'h1, 8'h01);
    tick(2);
    check(ticks, 8'h00);
    bus(1'b1, 3'h1, 8'h00);
    tick(4);
    check(ticks != 8'h00, 1'b1);
    bus(1'b1, 3'h0, 8'h80);
    tick(2);
    frozen = ticks;
    tick(5);
    check(ticks, frozen);
    for (i = 0; i < 5; i++)
      bus(1'b1, i[2:0], 8'hFF);
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    addr <= 3'h1;
    wdata <= 32'h0;
    wr <= 1'b1;
    tick(3);
    check(waitreq, 1'b1);
    check({8'h00, clk_off}, 32'h00FFFFFF);
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    @(posedge clock_in);
    while (waitreq !== 1'b0)
      @(posedge clock_in);
    wr <= 1'b0;
    tick(2);
    check({8'h00, clk_off}, 32'h00F87FFF);
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    tick(1);
    check({8'h00, clk_off}, 32'h0);
    check(gate_en, 1'b1);
    for (i = 0; i < 5; i++)
    begin
      bus(1'b0, i[2:0], 8'h00);
      check(got, 32'h0);
    end
    complete_run();
  end
endmodule

`default_nettype wire
